// >>> fault_pkg.sv
package fault_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] IRQ_OFS = 8'h0c;
    localparam logic [7:0] ID_OFS = 8'h10;

    // control register field positions
    localparam int CLEAR_FAULT_BIT = 0;
    localparam int UV_OFF_BIT = 1;
    localparam int OV_OFF_BIT = 2;
    localparam int OCP_SEL_LSB = 3;

    // overcurrent response encodings
    localparam logic [1:0] OCP_LATCH = 2'h0;
    localparam logic [1:0] OCP_RETRY = 2'h1;
    localparam logic [1:0] OCP_REPORT = 2'h2;
    localparam logic [1:0] OCP_DISABLE = 2'h3;

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // arbitrary identification value
    localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;

    // retry delay, time and derived cycles at 25 MHz
    localparam int CLOCK_HZ = 25_000_000;
    localparam int RETRY_US = 4000;
    localparam int RETRY_CYCLES = (RETRY_US * (CLOCK_HZ / 1_000_000));

    // status / interrupt bit positions
    localparam int ST_SUMMARY = 0;
    localparam int ST_SUPPLY_UV = 1;
    localparam int ST_SUPPLY_OV = 2;
    localparam int ST_SWITCH_OC = 3;
    localparam int ST_SHUNT_OC = 4;
    localparam int ST_GATE_V = 5;
    localparam int ST_OTHER = 6;
    localparam int ST_LOGIC_UV = 7;

    typedef enum logic [1:0] {
        MODE_OPERATING = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_SHUTDOWN = 2'b11
    } dev_mode_e;

    // live fault conditions from the analog monitors
    typedef struct packed {
        logic logic_rail_uv;
        logic supply_uv;
        logic supply_ov;
        logic switch_drop_overcurrent;
        logic shunt_overcurrent;
        logic gate_voltage_fault;
        logic drive_rail_overvoltage;
        logic other_fault;
    } fault_in_s;

    // power and driver controls
    typedef struct packed {
        logic gate_block;
        logic gate_hiz_pulldown;
        logic first_regulator_en;
        logic second_regulator_en;
        logic third_regulator_en;
        logic buck_en;
        logic pump_en;
        logic pump_buck_hiz;
    } power_ctl_s;

    typedef struct packed {
        logic [7:0] sync;
        logic [7:0] live;
    } sync_s;

endpackage : fault_pkg

// >>> level_sync.sv
`timescale 1ns/1ns
`default_nettype none

module level_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // two flops, first read only by second
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule : level_sync

`default_nettype wire

// >>> mcu_model.sv
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fault_line_n,
    output logic in_handling
);
    // fault routine while the line is low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_handling <= 1'b0;
        end else begin
            in_handling <= !fault_line_n;
        end
    end
endmodule : mcu_model
`default_nettype wire

// >>> supply_fault_manager.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - fault pin low while any fault present, except overcurrent with the disable response selected
// - release only when faults gone, rails up
// - latch pin only for overcurrent and gate faults
// - enable toggle or clear releases latched pin
// - status cleared by enable rise or clear
// - logic rail undervoltage enters Shutdown, blocks drivers
// - logic rail recovery moves to Sleep
// - supply undervoltage blocks drivers, second regulator, buck and pump off
// - supply undervoltage recovery auto releases, flags stay
// - undervoltage detect off: report only
// - supply overvoltage blocks drivers, second regulator, buck and pump off
// - overvoltage recovery restarts second regulator, buck and pump, drivers stay blocked
// - overvoltage detect off: report only
// - drive rail recovery releases pump buck hiz
// - retry mode releases after retry delay
module supply_fault_manager
    import fault_pkg::*;
#(
    parameter int RETRY_COUNT = RETRY_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire fault_pkg::fault_in_s FAULTS,
    input wire logic ENABLE_PIN,
    input wire logic RAILS_READY,
    output logic FAULT_INDICATOR_N_O,
    output logic FAULT_INDICATOR_N_OE,
    output fault_pkg::power_ctl_s POWER_CTL,
    output fault_pkg::dev_mode_e DEVICE_MODE,
    output logic IRQ
);
    import fault_pkg::*;

    typedef struct packed {
        logic supply_uv_detect_off;
        logic supply_ov_detect_off;
        logic [1:0] overcurrent_response_sel;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] irq_status;
        logic pin_latch;
        logic ov_gate_hold;
        logic oc_gate_hold;
        logic retry_active;
        logic [31:0] retry_cnt;
        logic drv_ov_seen;
        logic en_prev;
        logic en_was_low;
        logic [31:0] prdata;
        dev_mode_e mode;
    } state_s;

    state_s q, d;
    logic [7:0] sync_out;
    fault_in_s f;
    logic en_s;
    logic rails_s;
    logic apb_wr;
    logic apb_rd;
    logic clear_fault_cmd;
    logic en_rise;
    logic clear_evt;
    logic oc_live;
    logic [7:0] event_set;
    logic live_pin_low;

    // external pins cross into the clock domain
    level_sync #(.WIDTH(8)) u_sync_faults (
        .clk(CLOCK),
        .rst_b(RST_B),
        .din(FAULTS),
        .dout(sync_out)
    );

    level_sync #(.WIDTH(2)) u_sync_pins (
        .clk(CLOCK),
        .rst_b(RST_B),
        .din({ENABLE_PIN, RAILS_READY}),
        .dout({en_s, rails_s})
    );

    assign f = fault_in_s'(sync_out);

    // apb strobes, zero wait state
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = q.prdata;

    // clear command is a one-cycle write pulse, never stored
    assign clear_fault_cmd = apb_wr && (PADDR == CTRL_OFS) && PWDATA[CLEAR_FAULT_BIT];
    // rising edge that ends an enable low pulse
    assign en_rise = en_s && !q.en_prev && q.en_was_low;
    assign clear_evt = clear_fault_cmd || en_rise;

    assign oc_live = f.switch_drop_overcurrent || f.shunt_overcurrent;

    // new events for status flags
    always_comb begin
        event_set = '0;
        event_set[ST_SUPPLY_UV] = f.supply_uv;
        event_set[ST_SUPPLY_OV] = f.supply_ov;
        event_set[ST_SWITCH_OC] = f.switch_drop_overcurrent && (q.overcurrent_response_sel != OCP_DISABLE);
        event_set[ST_SHUNT_OC] = f.shunt_overcurrent && (q.overcurrent_response_sel != OCP_DISABLE);
        event_set[ST_GATE_V] = f.gate_voltage_fault;
        event_set[ST_OTHER] = f.other_fault || f.drive_rail_overvoltage;
        event_set[ST_LOGIC_UV] = f.logic_rail_uv;
        event_set[ST_SUMMARY] = |event_set[7:1];
    end

    // live conditions holding the pin low
    assign live_pin_low = f.logic_rail_uv || f.supply_uv || f.supply_ov || f.other_fault
        || f.drive_rail_overvoltage || f.gate_voltage_fault
        || (oc_live && (q.overcurrent_response_sel != OCP_DISABLE));

    // next-state logic
    always_comb begin
        d = q;
        d.en_prev = en_s;
        if (!en_s) begin
            d.en_was_low = 1'b1;
        end else if (en_rise) begin
            d.en_was_low = 1'b0;
        end

        // register writes
        if (apb_wr) begin
            case (PADDR)
                CTRL_OFS: begin
                    d.supply_uv_detect_off = PWDATA[UV_OFF_BIT];
                    d.supply_ov_detect_off = PWDATA[OV_OFF_BIT];
                    d.overcurrent_response_sel = PWDATA[OCP_SEL_LSB +: 2];
                end
                MASK_OFS: d.mask = PWDATA[7:0];
                IRQ_OFS: d.irq_status = q.irq_status & ~PWDATA[7:0];
                default: d.mask = q.mask;
            endcase
        end

        // status: clear first, new events win over clear
        if (clear_evt) begin
            d.status = '0;
            d.oc_gate_hold = 1'b0;
            d.ov_gate_hold = 1'b0;
        end
        if (q.retry_active && q.retry_cnt == 32'(RETRY_COUNT - 1)) begin
            d.status[ST_SWITCH_OC] = 1'b0;
            d.status[ST_SHUNT_OC] = 1'b0;
            d.retry_active = 1'b0;
            d.oc_gate_hold = 1'b0;
            d.retry_cnt = '0;
        end else if (q.retry_active) begin
            d.retry_cnt = q.retry_cnt + 32'd1;
        end
        d.status = d.status | event_set;
        d.irq_status = d.irq_status | event_set;

        // pin latch for overcurrent and gate faults
        if (clear_evt && !f.gate_voltage_fault && !oc_live) begin
            d.pin_latch = 1'b0;
        end
        if (f.gate_voltage_fault
            || (oc_live && q.overcurrent_response_sel != OCP_DISABLE
                && q.overcurrent_response_sel != OCP_RETRY)) begin
            d.pin_latch = 1'b1;
        end
        if (oc_live && q.overcurrent_response_sel == OCP_RETRY) begin
            d.retry_active = 1'b1;
            d.retry_cnt = '0;
            d.oc_gate_hold = 1'b1;
        end
        if (f.gate_voltage_fault
            || (oc_live && q.overcurrent_response_sel == OCP_LATCH)) begin
            d.oc_gate_hold = 1'b1;
        end
        if (f.supply_ov && !q.supply_ov_detect_off) begin
            d.ov_gate_hold = 1'b1;
        end
        if (f.drive_rail_overvoltage) begin
            d.drv_ov_seen = 1'b1;
        end else if (q.drv_ov_seen) begin
            d.drv_ov_seen = 1'b0;
        end

        // device mode
        // logic rail undervoltage outranks the enable pin
        if (f.logic_rail_uv) begin
            d.mode = MODE_SHUTDOWN;
        end else begin
            case (q.mode)
                MODE_SHUTDOWN: d.mode = MODE_SLEEP;
                MODE_SLEEP: if (en_s) d.mode = MODE_OPERATING;
                default: if (!en_s) d.mode = MODE_SLEEP;
            endcase
        end

        // read data
        d.prdata = '0;
        if (apb_rd) begin
            case (PADDR)
                CTRL_OFS: d.prdata = {27'h0, q.overcurrent_response_sel,
                    q.supply_ov_detect_off, q.supply_uv_detect_off, 1'b0};
                STATUS_OFS: d.prdata = {24'h0, q.status};
                MASK_OFS: d.prdata = {24'h0, q.mask};
                IRQ_OFS: d.prdata = {24'h0, q.irq_status};
                ID_OFS: d.prdata = BLOCK_ID;
                default: d.prdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            q <= '0;
            q.supply_uv_detect_off <= CTRL_RESET[UV_OFF_BIT];
            q.supply_ov_detect_off <= CTRL_RESET[OV_OFF_BIT];
            q.overcurrent_response_sel <= CTRL_RESET[OCP_SEL_LSB +: 2];
            q.mask <= MASK_RESET;
            q.mode <= MODE_SLEEP;
        end else begin
            q <= d;
        end
    end

    // pin drives low on live fault, latch, pending retry, or rails not ready
    always_comb begin
        FAULT_INDICATOR_N_O = 1'b0;
        FAULT_INDICATOR_N_OE = live_pin_low || q.pin_latch || q.retry_active || !rails_s;
    end

    // power and gate-driver controls
    always_comb begin
        logic uv_act;
        logic ov_act;
        uv_act = f.supply_uv && !q.supply_uv_detect_off;
        ov_act = f.supply_ov && !q.supply_ov_detect_off;
        POWER_CTL = '0;
        POWER_CTL.first_regulator_en = 1'b1;
        POWER_CTL.third_regulator_en = 1'b1;
        if (q.mode == MODE_SHUTDOWN) begin
            POWER_CTL.gate_block = 1'b1;
            POWER_CTL.gate_hiz_pulldown = 1'b1;
        end else begin
            POWER_CTL.second_regulator_en = !(uv_act || ov_act);
            POWER_CTL.buck_en = !(uv_act || ov_act) && !f.drive_rail_overvoltage;
            POWER_CTL.pump_en = !(uv_act || ov_act) && !f.drive_rail_overvoltage;
            POWER_CTL.pump_buck_hiz = f.drive_rail_overvoltage;
            POWER_CTL.gate_block = uv_act || ov_act || q.ov_gate_hold || q.oc_gate_hold;
            POWER_CTL.gate_hiz_pulldown = POWER_CTL.gate_block;
        end
    end

    assign DEVICE_MODE = q.mode;
    assign IRQ = |(q.irq_status & q.mask);

endmodule : supply_fault_manager

`default_nettype wire

// >>> supply_fault_manager_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module supply_fault_manager_chk (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire fault_pkg::fault_in_s FAULTS,
    input wire logic ENABLE_PIN,
    input wire logic RAILS_READY,
    input wire logic FAULT_INDICATOR_N_OE,
    input wire fault_pkg::power_ctl_s POWER_CTL,
    input wire fault_pkg::dev_mode_e DEVICE_MODE
);
    import fault_pkg::*;
    logic ctl_wr, clr_wr, uv_off_q, ov_off_q;
    // control writes, taken where the design takes them
    assign ctl_wr = PSEL && PENABLE && PWRITE && PADDR == CTRL_OFS;
    assign clr_wr = ctl_wr && PWDATA[CLEAR_FAULT_BIT];
    // detect-off bits as last written
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            uv_off_q <= 1'b0;
            ov_off_q <= 1'b0;
        end else if (ctl_wr) begin
            uv_off_q <= PWDATA[UV_OFF_BIT];
            ov_off_q <= PWDATA[OV_OFF_BIT];
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    a_live_pin: assert property (
        (FAULTS.supply_uv || FAULTS.supply_ov || FAULTS.logic_rail_uv)[*5] |-> FAULT_INDICATOR_N_OE) else $error("pin free");
    a_rails_pin: assert property (
        (!RAILS_READY)[*5] |-> FAULT_INDICATOR_N_OE) else $error("pin free, rails down");
    a_clear_release: assert property (
        (FAULTS == '0 && RAILS_READY)[*5] ##0 clr_wr |-> ##[1:2] !FAULT_INDICATOR_N_OE) else $error("clear kept pin");
    a_logic_uv_off: assert property (
        FAULTS.logic_rail_uv[*5] |-> DEVICE_MODE == MODE_SHUTDOWN && POWER_CTL.gate_block
        && POWER_CTL.first_regulator_en && POWER_CTL.third_regulator_en && !POWER_CTL.buck_en) else $error("no shutdown");
    a_shutdown_exit: assert property (
        $past(DEVICE_MODE) == MODE_SHUTDOWN && DEVICE_MODE != MODE_SHUTDOWN |-> DEVICE_MODE == MODE_SLEEP)
        else $error("shutdown exit not sleep");
    a_uv_block: assert property (
        (FAULTS.supply_uv && !uv_off_q)[*5] |-> POWER_CTL.gate_block && !POWER_CTL.second_regulator_en
        && !POWER_CTL.pump_en && POWER_CTL.third_regulator_en) else $error("uv not blocked");
    a_ov_block: assert property (
        (FAULTS.supply_ov && !ov_off_q)[*5] |-> POWER_CTL.gate_block && !POWER_CTL.buck_en
        && POWER_CTL.first_regulator_en) else $error("ov not blocked");
    a_ov_gate_hold: assert property (
        $fell(FAULTS.supply_ov) && !ov_off_q && POWER_CTL.gate_block ##1 (ENABLE_PIN && !clr_wr)[*5]
        |-> POWER_CTL.gate_block) else $error("gate freed early");
    a_hiz_release: assert property (
        (!FAULTS.drive_rail_overvoltage)[*5] |-> !POWER_CTL.pump_buck_hiz) else $error("hiz kept");
endmodule : supply_fault_manager_chk
bind supply_fault_manager supply_fault_manager_chk chk_u (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .FAULTS(FAULTS),
    .ENABLE_PIN(ENABLE_PIN), .RAILS_READY(RAILS_READY), .FAULT_INDICATOR_N_OE(FAULT_INDICATOR_N_OE),
    .POWER_CTL(POWER_CTL), .DEVICE_MODE(DEVICE_MODE));
`default_nettype wire

// >>> test_supply_fault_manager.sv
`timescale 1ns/1ns
`default_nettype none
module test_supply_fault_manager;
    import fault_pkg::*;
    localparam int RETRY = 8;
    logic clock, rst_b, psel, penable, pwrite, enable_pin, rails_ready, pready, pslverr, oe, fo, irq, handling;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    fault_in_s faults;
    power_ctl_s pwr;
    dev_mode_e mode;
    int miscompares = 0, comparisons = 0, cycles = 0;
    wire fault_n = oe ? fo : 1'b1; // pull-up on the open-drain line
    supply_fault_manager #(.RETRY_COUNT(RETRY)) dut_u (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FAULTS(faults), .ENABLE_PIN(enable_pin), .RAILS_READY(rails_ready),
        .FAULT_INDICATOR_N_O(fo), .FAULT_INDICATOR_N_OE(oe), .POWER_CTL(pwr), .DEVICE_MODE(mode), .IRQ(irq));
    mcu_model mcu_u (.clk(clock), .rst_b(rst_b), .fault_line_n(fault_n), .in_handling(handling));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic t_regs();
        apb(1'b1, STATUS_OFS, 32'hffff_ffff);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, MASK_OFS, 32'h0);
        chk("mask", {24'h0, MASK_RESET}, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("slverr", 32'h0, pslverr);
        apb(1'b0, ID_OFS, 32'h0);
        chk("id", BLOCK_ID, rd);
        apb(1'b1, CTRL_OFS, 32'h1f);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", 32'h1e, rd);
        apb(1'b1, CTRL_OFS, CTRL_RESET);
        chk("pin idle", 1'b0, oe);
        chk("pin level", 1'b0, fo);
    endtask : t_regs
    task automatic t_uv();
        apb(1'b1, MASK_OFS, 32'h2);
        faults.supply_uv <= 1'b1;
        wt(5);
        chk("uv pin", 1'b1, oe);
        chk("mcu", 1'b1, handling);
        chk("irq", 1'b1, irq);
        faults.supply_uv <= 1'b0;
        wt(5);
        chk("uv pin", 1'b0, oe);
        chk("uv gate", 1'b0, pwr.gate_block);
        apb(1'b1, MASK_OFS, 32'h0);
        wt(2);
        chk("irq masked", 1'b0, irq);
        apb(1'b1, MASK_OFS, 32'h2);
        apb(1'b1, IRQ_OFS, 32'h2);
        wt(2);
        chk("irq clear", 1'b0, irq);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("uv flags", 32'h3, rd);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("uv flags", 32'h0, rd);
    endtask : t_uv
    task automatic t_ov();
        faults.supply_ov <= 1'b1;
        wt(5);
        chk("ov pin", 1'b1, oe);
        faults.supply_ov <= 1'b0;
        wt(5);
        chk("ov pin", 1'b0, oe);
        chk("ov buck", 1'b1, pwr.buck_en);
        chk("ov gate", 1'b1, pwr.gate_block);
        enable_pin <= 1'b0;
        wt(4);
        enable_pin <= 1'b1;
        wt(5);
        chk("ov gate", 1'b0, pwr.gate_block);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("ov flags", 32'h0, rd);
    endtask : t_ov
    // b is the detect-off bit; the matching fault sits at bit 7-b of the struct
    task automatic t_off(input int b);
        apb(1'b1, CTRL_OFS, 32'h1 << b);
        faults[7-b] <= 1'b1;
        wt(5);
        chk("off pin", 1'b1, oe);
        chk("off gate", 1'b0, pwr.gate_block);
        faults[7-b] <= 1'b0;
        wt(5);
        chk("off pin", 1'b0, oe);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("off flags", 32'h1 | (32'h1 << b), rd);
        apb(1'b1, CTRL_OFS, 32'h1);
        faults[7-b] <= 1'b1;
        wt(5);
        faults[7-b] <= 1'b0;
        wt(5);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("flags again", 32'h1 | (32'h1 << b), rd);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("clear again", 32'h0, rd);
    endtask : t_off
    task automatic t_latch();
        faults.gate_voltage_fault <= 1'b1;
        wt(5);
        faults.gate_voltage_fault <= 1'b0;
        wt(5);
        chk("gate latch", 1'b1, oe);
        apb(1'b1, CTRL_OFS, 32'h1);
        wt(2);
        chk("gate clear", 1'b0, oe);
        apb(1'b1, CTRL_OFS, {27'h0, OCP_RETRY, 3'h0});
        faults.switch_drop_overcurrent <= 1'b1;
        wt(5);
        chk("oc pin", 1'b1, oe);
        faults.switch_drop_overcurrent <= 1'b0;
        wt(4);
        chk("retry hold", 1'b1, oe);
        chk("retry gate", 1'b1, pwr.gate_block);
        wt(RETRY + 2);
        chk("retry", 1'b0, oe);
        chk("retry gate", 1'b0, pwr.gate_block);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("retry flags", 32'h1 << ST_SUMMARY, rd);
        apb(1'b1, CTRL_OFS, {27'h0, OCP_REPORT, 3'h0});
        faults.shunt_overcurrent <= 1'b1;
        wt(5);
        faults.shunt_overcurrent <= 1'b0;
        wt(5);
        chk("report pin", 1'b1, oe);
        chk("report gate", 1'b0, pwr.gate_block);
        apb(1'b1, CTRL_OFS, {27'h0, OCP_DISABLE, 3'h1});
        wt(2);
        chk("report clear", 1'b0, oe);
        faults.shunt_overcurrent <= 1'b1;
        wt(5);
        chk("disabled pin", 1'b0, oe);
        faults.shunt_overcurrent <= 1'b0;
        wt(5);
        apb(1'b1, CTRL_OFS, 32'h1);
    endtask : t_latch
    task automatic t_power();
        enable_pin <= 1'b0;
        faults.logic_rail_uv <= 1'b1;
        wt(5);
        chk("mode", MODE_SHUTDOWN, mode);
        faults.logic_rail_uv <= 1'b0;
        wt(5);
        chk("mode", MODE_SLEEP, mode);
        enable_pin <= 1'b1;
        rails_ready <= 1'b0;
        wt(5);
        chk("rails", 1'b1, oe);
        rails_ready <= 1'b1;
        wt(5);
        chk("rails", 1'b0, oe);
        faults.drive_rail_overvoltage <= 1'b1;
        wt(5);
        chk("drv hiz", 1'b1, pwr.pump_buck_hiz);
        chk("drv buck", 1'b0, pwr.buck_en);
        faults.drive_rail_overvoltage <= 1'b0;
        wt(5);
        chk("drv hiz", 1'b0, pwr.pump_buck_hiz);
        chk("drv buck", 1'b1, pwr.buck_en);
    endtask : t_power
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        faults = '0;
        enable_pin = 1'b1;
        rails_ready = 1'b1;
        wt(2);
        rst_b <= 1'b1;
        wt(4);
        t_regs();
        t_uv();
        t_ov();
        t_off(UV_OFF_BIT);
        t_off(OV_OFF_BIT);
        t_latch();
        t_power();
        final_report();
    end
endmodule : test_supply_fault_manager
`default_nettype wire
